/* rtl/pci_power_state_capability.sv */
// power-state sequencing and capability register for the pci function
`default_nettype none
module pci_power_state_capability
    import pm_cap_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic eeprom_valid_i,
    input wire logic [15:0] eeprom_bus_param_word_i,
    input wire logic spec_rev_1_1_i,
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [15:0] cfg_wdata_i,
    input wire logic aux_power_i,
    input wire logic wake_event_i,
    output logic [15:0] cfg_rdata_o,
    output logic [1:0] current_power_level_o,
    output logic io_mem_enable_o,
    output logic master_enable_o,
    output logic cfg_enable_o,
    output logic smbus_enable_o,
    output logic cfg_clear_o,
    output logic pme_n_o,
    output logic pme_oe_o
);
    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic ee_valid_s;
    logic aux_s;
    logic wake_s;
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
        end
        else
        begin
            sync1_r <= {eeprom_valid_i, aux_power_i, wake_event_i};
            sync2_r <= sync1_r;
        end
    end
    assign ee_valid_s = sync2_r[2];
    assign aux_s = sync2_r[1];
    assign wake_s = sync2_r[0];

    // ----------------------------------------
    // capability register
    // ----------------------------------------
    logic [15:0] power_capability_info_r;
    logic [15:0] cap_nxt;
    logic loaded_r;
    logic loaded_nxt;
    always_comb
    begin
        cap_nxt = power_capability_info_r;
        loaded_nxt = loaded_r;
        if (ee_valid_s && !loaded_r)
        begin
            loaded_nxt = 1'b1;
            cap_nxt[VER_MSB:VER_LSB] = spec_rev_1_1_i ? VER_1_1 : VER_1_0;
            cap_nxt[D1_BIT] = eeprom_bus_param_word_i[PARM_D1_BIT];
            cap_nxt[D2_BIT] = eeprom_bus_param_word_i[PARM_D2_BIT];
            cap_nxt[WAKE_MSB:WAKE_LSB] = eeprom_bus_param_word_i[PARM_WAKE_MSB:PARM_WAKE_LSB];
        end
        cap_nxt[8:3] = 6'h00;
    end
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            power_capability_info_r <= CAP_RESET;
            loaded_r <= 1'b0;
        end
        else
        begin
            power_capability_info_r <= cap_nxt;
            loaded_r <= loaded_nxt;
        end
    end

    // ----------------------------------------
    // power state and control
    // ----------------------------------------
    power_level_t level_r;
    power_level_t level_nxt;
    logic pme_en_r;
    logic pme_en_nxt;
    logic pme_sts_r;
    logic pme_sts_nxt;
    logic clear_r;
    logic clear_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic ctrl_wr;
    logic wake_ok;
    logic [1:0] req_level;
    assign ctrl_wr = cfg_wr_i && cfg_addr_i == CTRL_OFFSET;
    assign req_level = cfg_wdata_i[1:0];
    always_comb
    begin
        level_nxt = level_r;
        pme_en_nxt = pme_en_r;
        pme_sts_nxt = pme_sts_r;
        clear_nxt = 1'b0;
        rdata_nxt = rdata_r;
        wake_ok = 1'b0;
        unique case (level_r)
            PWR_D0: wake_ok = power_capability_info_r[WAKE_LSB];
            PWR_D1: wake_ok = power_capability_info_r[WAKE_LSB + 1];
            PWR_D2: wake_ok = power_capability_info_r[WAKE_LSB + 2];
            PWR_D3: wake_ok = aux_s ? power_capability_info_r[WAKE_LSB + 3]
                                    : 1'b0;
        endcase
        if (ctrl_wr)
        begin
            pme_en_nxt = cfg_wdata_i[PME_EN_BIT];
            if (cfg_wdata_i[PME_STS_BIT])
            begin
                pme_sts_nxt = 1'b0;
            end
            if (req_level == PWR_D0 || req_level == PWR_D3
                || (req_level == PWR_D1 && power_capability_info_r[D1_BIT])
                || (req_level == PWR_D2 && power_capability_info_r[D2_BIT]))
            begin
                level_nxt = power_level_t'(req_level);
                if (req_level == PWR_D3 && level_r != PWR_D3)
                begin
                    clear_nxt = 1'b1;
                end
            end
        end
        // set wins over clear
        if (wake_s && wake_ok)
        begin
            pme_sts_nxt = 1'b1;
        end
        if (cfg_rd_i)
        begin
            if (cfg_addr_i == CAP_OFFSET)
            begin
                rdata_nxt = power_capability_info_r;
            end
            else if (cfg_addr_i == CTRL_OFFSET)
            begin
                rdata_nxt = {pme_sts_r, 6'h00, pme_en_r, 6'h00, level_r};
            end
            else
            begin
                rdata_nxt = 16'h0000;
            end
        end
    end
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            level_r <= PWR_D0;
            pme_en_r <= 1'b0;
            pme_sts_r <= 1'b0;
            clear_r <= 1'b0;
            rdata_r <= CTRL_RESET;
        end
        else
        begin
            level_r <= level_nxt;
            pme_en_r <= pme_en_nxt;
            pme_sts_r <= pme_sts_nxt;
            clear_r <= clear_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ----------------------------------------
    // bus enables and wake pin
    // ----------------------------------------
    logic io_en_r;
    logic cfg_en_r;
    logic smb_en_r;
    logic pme_drv_r;
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            io_en_r <= 1'b0;
            cfg_en_r <= 1'b0;
            smb_en_r <= 1'b0;
            pme_drv_r <= 1'b0;
        end
        else
        begin
            io_en_r <= level_nxt == PWR_D0;
            cfg_en_r <= 1'b1;
            smb_en_r <= level_nxt != PWR_D3 || aux_s;
            pme_drv_r <= pme_sts_nxt && pme_en_nxt;
        end
    end
    assign cfg_rdata_o = rdata_r;
    assign current_power_level_o = level_r;
    assign io_mem_enable_o = io_en_r;
    assign master_enable_o = io_en_r;
    assign cfg_enable_o = cfg_en_r;
    assign smbus_enable_o = smb_en_r;
    assign cfg_clear_o = clear_r;
    assign pme_n_o = 1'b0;
    assign pme_oe_o = pme_drv_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_sleep_blocks_io: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (level_r != PWR_D0) |-> !io_mem_enable_o)
        else $error("io enabled while asleep");
    a_d3_entry_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (level_r != PWR_D3 && level_nxt == PWR_D3) |=> cfg_clear_o)
        else $error("no config clear on D3 entry");
    a_d2_needs_flag: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (level_nxt == PWR_D2 && level_r != PWR_D2) |-> power_capability_info_r[D2_BIT])
        else $error("D2 entered without support");
    a_cap_zero_bits: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        power_capability_info_r[8:3] == 6'h00)
        else $error("reserved capability bits set");
    a_wake_drives_pme: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (wake_s && wake_ok && pme_en_r && !ctrl_wr) |=> pme_oe_o)
        else $error("wake event not signalled");
    a_cap_d1_load: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (ee_valid_s && !loaded_r) |=> power_capability_info_r[D1_BIT] == $past(eeprom_bus_param_word_i[PARM_D1_BIT]))
        else $error("D1 support not loaded");
    a_cfg_always: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $past(rst_n_i) |-> cfg_enable_o)
        else $error("config access blocked");
    a_d3cold_quiet: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (level_nxt == PWR_D3 && !aux_s) |=> !smbus_enable_o)
        else $error("smbus active without aux power");
endmodule : pci_power_state_capability
`default_nettype wire

/* include/pm_cap_pkg.sv */
// constants and types for the power-state and capability block
`default_nettype none
package pm_cap_pkg;
    localparam logic [15:0] CAP_RESET = 16'h7601;
    localparam logic [7:0] CAP_OFFSET = 8'h00;
    localparam logic [7:0] CTRL_OFFSET = 8'h02;
    localparam int VER_LSB = 0;
    localparam int VER_MSB = 2;
    localparam int D1_BIT = 9;
    localparam int D2_BIT = 10;
    localparam int WAKE_LSB = 11;
    localparam int WAKE_MSB = 15;
    localparam int PARM_D1_BIT = 4;
    localparam int PARM_D2_BIT = 5;
    localparam int PARM_WAKE_LSB = 11;
    localparam int PARM_WAKE_MSB = 15;
    localparam int PME_EN_BIT = 8;
    localparam int PME_STS_BIT = 15;
    localparam logic [2:0] VER_1_0 = 3'h1;
    localparam logic [2:0] VER_1_1 = 3'h2;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    typedef enum logic [1:0]
    {
        PWR_D0 = 2'b00,
        PWR_D1 = 2'b01,
        PWR_D2 = 2'b10,
        PWR_D3 = 2'b11
    } power_level_t;
endpackage : pm_cap_pkg
`default_nettype wire

/* bench/pm_host_model.sv */
// host model issuing configuration cycles
`default_nettype none
module pm_host_model
(
    input wire logic mclk_i,
    output logic cfg_wr_o,
    output logic cfg_rd_o,
    output logic [7:0] cfg_addr_o,
    output logic [15:0] cfg_wdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        {cfg_wr_o, cfg_rd_o} = 2'h0;
        cfg_addr_o = 8'hA5;
        cfg_wdata_o = 16'h5A5A;
    end
    // one cycle; afterwards both strobes drop and address and data show the inverse of their last value
    task automatic cycle(input logic wr, input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        cfg_wr_o <= wr;
        cfg_rd_o <= ~wr;
        cfg_addr_o <= a;
        cfg_wdata_o <= d;
        @(posedge mclk_i);
        {cfg_wr_o, cfg_rd_o} <= 2'h0;
        cfg_addr_o <= ~a;
        cfg_wdata_o <= ~d;
    endtask : cycle
endmodule : pm_host_model
`default_nettype wire

/* bench/pci_power_state_capability_tb_top.sv */
// self-checking bench for the power-state and capability block
`default_nettype none
module pci_power_state_capability_tb_top;
    import pm_cap_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ee_vld = 1'b0;
    logic [15:0] w = 16'h0000;
    logic rev = 1'b0;
    logic aux = 1'b0;
    logic wake = 1'b0;
    logic wr, rd_s, clr, io, mst, cen, smb, pn, poe;
    logic [7:0] ad;
    logic [15:0] wd, rdat, cap;
    logic [1:0] lvl, st, s, nst;
    int n_fail = 0;
    int checked = 0;
    integer seed = 78;
    initial forever #5 mclk_i = ~mclk_i;
    pm_host_model pm_host_model_inst (.mclk_i(mclk_i), .cfg_wr_o(wr), .cfg_rd_o(rd_s), .cfg_addr_o(ad),
        .cfg_wdata_o(wd));
    pci_power_state_capability pci_power_state_capability_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .eeprom_valid_i(ee_vld), .eeprom_bus_param_word_i(w), .spec_rev_1_1_i(rev), .cfg_wr_i(wr),
        .cfg_rd_i(rd_s), .cfg_addr_i(ad), .cfg_wdata_i(wd), .aux_power_i(aux), .wake_event_i(wake),
        .cfg_rdata_o(rdat), .current_power_level_o(lvl), .io_mem_enable_o(io), .master_enable_o(mst),
        .cfg_enable_o(cen), .smbus_enable_o(smb), .cfg_clear_o(clr), .pme_n_o(pn), .pme_oe_o(poe));
    task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : check
    task automatic end_sim();
        if (n_fail == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        pm_host_model_inst.cycle(1'b0, a, 16'h0000);
        #1 check("rdata", e, rdat);
    endtask : rd
    initial
    begin
        for (int it = 0; it < 2; it++)
        begin
            @(posedge mclk_i);
            rst_n_i <= 1'b0;
            ee_vld <= 1'b0;
            w <= (it == 1) ? (16'($random(seed)) | 16'hF830) : 16'($random(seed));
            rev <= it[0];
            aux <= it[0];
            repeat (16) @(posedge mclk_i);
            rst_n_i <= 1'b1;
            st = 2'h0;
            rd(CAP_OFFSET, CAP_RESET);
            @(posedge mclk_i);
            ee_vld <= 1'b1;
            repeat (6) @(posedge mclk_i);
            cap = {w[15:11], w[5], w[4], 6'h00, it[0] ? VER_1_1 : VER_1_0};
            rd(CAP_OFFSET, cap);
            pm_host_model_inst.cycle(1'b1, CAP_OFFSET, 16'hFFFF);
            rd(CAP_OFFSET, cap);
            rd(8'h40, 16'h0000);
            for (int k = 0; k < 14; k++)
            begin
                s = (k < 4) ? k[1:0] : 2'($random(seed));
                pm_host_model_inst.cycle(1'b1, CTRL_OFFSET, {14'h0000, s});
                nst = ((s == 2'h1 && !w[4]) || (s == 2'h2 && !w[5])) ? st : s;
                #1 check("clear", {15'h0000, nst == 2'h3 && st != 2'h3}, clr);
                st = nst;
                check("level", {14'h0000, st}, {14'h0000, lvl});
                check("io_mem", {15'h0000, st == 2'h0}, io);
                check("master", {15'h0000, st == 2'h0}, mst);
                check("cfg_en", 16'h0001, cen);
                check("smbus", {15'h0000, !(st == 2'h3 && !it[0])}, smb);
                rd(CTRL_OFFSET, {14'h0000, st});
            end
            if (it == 0)
            begin
                // D3 with no aux power: a wake event must not reach the pin
                pm_host_model_inst.cycle(1'b1, CTRL_OFFSET, 16'h0103);
                wake <= 1'b1;
                repeat (6) @(posedge mclk_i);
                #1 check("pme_cold", 16'h0000, poe);
                check("smbus_cold", 16'h0000, smb);
                rd(CTRL_OFFSET, 16'h0103);
                @(posedge mclk_i);
                wake <= 1'b0;
            end
            else
            begin
                pm_host_model_inst.cycle(1'b1, CTRL_OFFSET, 16'h0102);
                wake <= 1'b1;
                for (int n = 0; n < 8 && poe !== 1'b1; n++) @(posedge mclk_i);
                #1 check("pme_oe", 16'h0001, poe);
                check("pme_n", 16'h0000, pn);
                rd(CTRL_OFFSET, 16'h8102);
                @(posedge mclk_i);
                wake <= 1'b0;
                repeat (4) @(posedge mclk_i);
                pm_host_model_inst.cycle(1'b1, CTRL_OFFSET, 16'h8102);
                #1 check("pme_off", 16'h0000, poe);
                rd(CTRL_OFFSET, 16'h0102);
            end
        end
        end_sim();
    end
    initial
    begin
        #500000;
        n_fail++;
        end_sim();
    end
endmodule : pci_power_state_capability_tb_top
`default_nettype wire
